// ---- logic/bcd_adjust_and_bit_op_execution.v ----
/*
  Execution unit for the decimal-adjust group, privilege adjust, blitter
  pointer rewinds, array limit check, bit scans and bit test-and-modify.
  Assumes one core clock, operands valid beside the start pulse, and a
  plain register port with read data one cycle after the read strobe.
*/
// Design decisions made here: the address-and-strobe port and the register offsets.
// Behaviour
// - 37 decimal adjust after add, 3 clocks
// - 3F decimal adjust after subtract, 3 clocks
// - D5 0A adjust before divide, 7 clocks
// - D4 0A adjust after multiply, 19 clocks
// - 63 privilege adjust, zero flag, 9 clocks, protected mode only
// - 0F 3A rewinds blit buffer 0, 2 clocks
// - 0F 3B rewinds blit buffer 1, 2 clocks
// - 62 out of range raises interrupt 5, 8 clocks
// - 62 in range finishes in 7, flags kept
// - 0F BC lowest bit scan, 4 or 9+n
// - 0F BD highest bit scan, 4 or 11+n
// - test-and-complement BA/111 or BB, carry only
// - test-and-clear BA/110 or B3, carry only
// - test-and-set BA/101, 2 clocks, carry only
// - counts assume register or cache hit operands
// - opcodes hex, bracketed subfields binary
// - undefined flags may hold any value
`timescale 1ns/1ps
`default_nettype none
`include "bcd_bitop_regs.vh"

module bcd_adjust_and_bit_op_execution (
  input wire clock,
  input wire rst,
  input wire start,
  input wire [7:0] opcode0,
  input wire [7:0] opcode1,
  input wire [7:0] modrm,
  input wire [7:0] imm8,
  input wire [31:0] operand_a,
  input wire [31:0] operand_b,
  input wire [31:0] bound_lower,
  input wire [31:0] bound_upper,
  input wire [7:0] address,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output wire busy,
  output reg done,
  output reg [31:0] result,
  output reg result_write,
  output wire [11:0] flags_out,
  output reg bound_fault,
  output reg blit_buffer0_pointer_rewind,
  output reg blit_buffer1_pointer_rewind,
  output reg illegal_opcode
);

  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  reg state_ff;
  reg [5:0] cnt_ff;
  reg [5:0] last_count_ff;
  reg protected_ff;
  reg [11:0] flags_ff;
  reg limit_fault_seen_ff;
  reg illegal_seen_ff;
  reg [31:0] pend_result_ff;
  reg [11:0] pend_flags_ff;
  reg pend_write_ff;
  reg pend_fault_ff;
  reg pend_rew0_ff;
  reg pend_rew1_ff;
  reg pend_illegal_ff;

  reg [31:0] nxt_result;
  reg [11:0] nxt_flags;
  reg [5:0] nxt_count;
  reg nxt_write;
  reg nxt_fault;
  reg nxt_rew0;
  reg nxt_rew1;
  reg nxt_illegal;

  wire scan_found;
  wire [4:0] scan_index;
  wire [5:0] scan_examined;
  wire [7:0] al = operand_a[7:0];
  wire [7:0] ah = operand_a[15:8];
  wire [15:0] ah_times_ten = ah * `OP_BASE_TEN;
  wire [7:0] aad_al = ah_times_ten[7:0] + al;
  wire [7:0] aam_ah = al / `OP_BASE_TEN;
  wire [7:0] aam_al = al % `OP_BASE_TEN;
  wire adj_needed = (al[3:0] > 4'h9) | flags_ff[`FLAG_AUX];
  wire mem_form = (modrm[7:6] != `MOD_REGISTER);
  wire bit_imm_form = (opcode1 == `OP2_BIT_IMM);
  wire [4:0] bit_idx = bit_imm_form ? imm8[4:0] : operand_b[4:0];
  wire [31:0] bit_mask = 32'h0000_0001 << bit_idx;
  wire tested_bit = operand_a[bit_idx];
  wire below_limit = $signed(operand_a) < $signed(bound_lower);
  wire above_limit = $signed(operand_a) > $signed(bound_upper);
  wire take = start & (state_ff == ST_IDLE);

  assign busy = (state_ff == ST_EXEC);
  assign flags_out = flags_ff;

  // ========================================================================
  // Bit scan helper
  bit_scan_unit #(
    .WIDTH(32)
  ) u_scan (
    .value(operand_b),
    .reverse(opcode1 == `OP2_SCAN_HIGH),
    .found(scan_found),
    .index(scan_index),
    .examined(scan_examined)
  );

  // ========================================================================
  // Decode and compute
  // Results are worked out at issue and held until the count expires, so
  // operands need only be valid beside the start pulse.
  // Undefined flags are simply left as they were, which software may not
  // rely on either way.
  always @* begin
    nxt_result = operand_a;
    nxt_flags = flags_ff;
    nxt_count = `CLK_ILLEGAL;
    nxt_write = 1'b0;
    nxt_fault = 1'b0;
    nxt_rew0 = 1'b0;
    nxt_rew1 = 1'b0;
    nxt_illegal = 1'b0;
    // Single-byte opcodes are matched as hex bytes, subfields as bit fields
    case (opcode0)
      `OP_DEC_ADD: begin
        nxt_count = `CLK_DEC_ADD;
        nxt_write = 1'b1;
        nxt_flags[`FLAG_AUX] = adj_needed;
        nxt_flags[`FLAG_CARRY] = adj_needed;
        if (adj_needed) nxt_result[15:0] = {ah + 8'h01, 4'h0, al[3:0] + 4'h6};
        else nxt_result[15:0] = {ah, 4'h0, al[3:0]};
      end
      `OP_DEC_SUB: begin
        nxt_count = `CLK_DEC_SUB;
        nxt_write = 1'b1;
        nxt_flags[`FLAG_AUX] = adj_needed;
        nxt_flags[`FLAG_CARRY] = adj_needed;
        if (adj_needed) nxt_result[15:0] = {ah - 8'h01, 4'h0, al[3:0] - 4'h6};
        else nxt_result[15:0] = {ah, 4'h0, al[3:0]};
      end
      `OP_DEC_DIV: begin
        if (opcode1 == `OP_BASE_TEN) begin
          nxt_count = `CLK_DEC_DIV;
          nxt_write = 1'b1;
          nxt_result[15:0] = {8'h00, aad_al};
          nxt_flags[`FLAG_SIGN] = aad_al[7];
          nxt_flags[`FLAG_ZERO] = (aad_al == 8'h00);
          nxt_flags[`FLAG_PARITY] = ~^aad_al;
        end else begin
          nxt_illegal = 1'b1;
        end
      end
      `OP_DEC_MUL: begin
        if (opcode1 == `OP_BASE_TEN) begin
          nxt_count = `CLK_DEC_MUL;
          nxt_write = 1'b1;
          nxt_result[15:0] = {aam_ah, aam_al};
          nxt_flags[`FLAG_SIGN] = aam_al[7];
          nxt_flags[`FLAG_ZERO] = (aam_al == 8'h00);
          nxt_flags[`FLAG_PARITY] = ~^aam_al;
        end else begin
          nxt_illegal = 1'b1;
        end
      end
      `OP_PRIV_ADJ: begin
        // Only a protected-mode figure exists, so real mode refuses it
        if (protected_ff) begin
          nxt_count = `CLK_PRIV_ADJ;
          nxt_flags[`FLAG_ZERO] = (operand_a[1:0] < operand_b[1:0]);
          nxt_write = (operand_a[1:0] < operand_b[1:0]);
          nxt_result[1:0] = operand_b[1:0];
        end else begin
          nxt_illegal = 1'b1;
        end
      end
      `OP_LIMIT_CHK: begin
        if (below_limit | above_limit) begin
          nxt_count = `CLK_LIMIT_OUT;
          nxt_fault = 1'b1;
        end else begin
          nxt_count = `CLK_LIMIT_IN;
        end
      end
      `OP_ESCAPE: begin
        case (opcode1)
          `OP2_REWIND0: begin
            nxt_count = `CLK_REWIND;
            nxt_rew0 = 1'b1;
          end
          `OP2_REWIND1: begin
            nxt_count = `CLK_REWIND;
            nxt_rew1 = 1'b1;
          end
          `OP2_SCAN_LOW, `OP2_SCAN_HIGH: begin
            // Register form is fixed, memory form grows with bits examined
            if (!mem_form) nxt_count = `CLK_SCAN_REG;
            else if (opcode1 == `OP2_SCAN_LOW) nxt_count = `CLK_SCAN_LOW_MEM + scan_examined;
            else nxt_count = `CLK_SCAN_HIGH_MEM + scan_examined;
            nxt_flags[`FLAG_ZERO] = ~scan_found;
            nxt_write = scan_found;
            nxt_result = {27'h0000000, scan_index};
          end
          `OP2_BIT_IMM: begin
            nxt_count = `CLK_BIT_REG;
            nxt_write = 1'b1;
            nxt_flags[`FLAG_CARRY] = tested_bit;
            case (modrm[5:3])
              `SUB_BIT_CPL: nxt_result = operand_a ^ bit_mask;
              `SUB_BIT_CLR: nxt_result = operand_a & ~bit_mask;
              `SUB_BIT_SET: nxt_result = operand_a | bit_mask;
              default: begin
                nxt_count = `CLK_ILLEGAL;
                nxt_write = 1'b0;
                nxt_flags = flags_ff;
                nxt_illegal = 1'b1;
              end
            endcase
          end
          `OP2_BIT_CPL, `OP2_BIT_CLR: begin
            nxt_count = mem_form ? `CLK_BIT_MEM : `CLK_BIT_REG;
            nxt_write = 1'b1;
            nxt_flags[`FLAG_CARRY] = tested_bit;
            if (opcode1 == `OP2_BIT_CPL) nxt_result = operand_a ^ bit_mask;
            else nxt_result = operand_a & ~bit_mask;
          end
          default: begin
            nxt_illegal = 1'b1;
          end
        endcase
      end
      default: begin
        nxt_illegal = 1'b1;
      end
    endcase
  end

  // ========================================================================
  // Sequencer
  // The count is a register-or-cache-hit figure; miss stretching belongs to
  // the memory side, which holds start off until the operand is here.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 6'h00;
      last_count_ff <= 6'h00;
      pend_result_ff <= `RESULT_RST;
      pend_flags_ff <= `FLAGS_RST;
      pend_write_ff <= 1'b0;
      pend_fault_ff <= 1'b0;
      pend_rew0_ff <= 1'b0;
      pend_rew1_ff <= 1'b0;
      pend_illegal_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take) begin
            state_ff <= ST_EXEC;
            cnt_ff <= nxt_count - 6'h01;
            last_count_ff <= nxt_count;
            pend_result_ff <= nxt_result;
            pend_flags_ff <= nxt_flags;
            pend_write_ff <= nxt_write;
            pend_fault_ff <= nxt_fault;
            pend_rew0_ff <= nxt_rew0;
            pend_rew1_ff <= nxt_rew1;
            pend_illegal_ff <= nxt_illegal;
          end
        end
        ST_EXEC: begin
          if (cnt_ff == 6'h00) state_ff <= ST_IDLE;
          else cnt_ff <= cnt_ff - 6'h01;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  wire finish = (state_ff == ST_EXEC) && (cnt_ff == 6'h00);

  // ========================================================================
  // Completion pulses one cycle after the last counted clock; result holds until the next write
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      result <= `RESULT_RST;
      result_write <= 1'b0;
      bound_fault <= 1'b0;
      blit_buffer0_pointer_rewind <= 1'b0;
      blit_buffer1_pointer_rewind <= 1'b0;
      illegal_opcode <= 1'b0;
    end else begin
      done <= finish;
      result_write <= finish & pend_write_ff;
      bound_fault <= finish & pend_fault_ff;
      blit_buffer0_pointer_rewind <= finish & pend_rew0_ff;
      blit_buffer1_pointer_rewind <= finish & pend_rew1_ff;
      illegal_opcode <= finish & pend_illegal_ff;
      if (finish & pend_write_ff) result <= pend_result_ff;
    end
  end

  // ========================================================================
  // Register file
  // A finishing instruction beats a software flag write in the same cycle,
  // and a sticky event beats its own clear.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      protected_ff <= `CONTROL_RST;
      flags_ff <= `FLAGS_RST;
      limit_fault_seen_ff <= 1'b0;
      illegal_seen_ff <= 1'b0;
    end else begin
      if (wr && address == `REG_CONTROL) protected_ff <= wdata[`CTRL_PROTECTED];
      if (finish) flags_ff <= pend_flags_ff;
      else if (wr && address == `REG_FLAGS) flags_ff <= wdata[11:0];
      if (finish & pend_fault_ff) limit_fault_seen_ff <= 1'b1;
      else if (wr && address == `REG_STATUS && wdata[`STAT_LIMIT_FAULT]) limit_fault_seen_ff <= 1'b0;
      if (finish & pend_illegal_ff) illegal_seen_ff <= 1'b1;
      else if (wr && address == `REG_STATUS && wdata[`STAT_ILLEGAL]) illegal_seen_ff <= 1'b0;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (address)
        `REG_CONTROL: rdata <= {31'h00000000, protected_ff};
        `REG_FLAGS: rdata <= {20'h00000, flags_ff};
        `REG_STATUS: rdata <= {29'h00000000, illegal_seen_ff, limit_fault_seen_ff, busy};
        `REG_RESULT: rdata <= result;
        `REG_LAST_COUNT: rdata <= {26'h0000000, last_count_ff};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule // bcd_adjust_and_bit_op_execution

`default_nettype wire

// ---- common/bcd_bitop_regs.vh ----
/*
  Constants for the decimal-adjust and bit-operation execution unit:
  opcode bytes, clock counts, flag bit positions, register offsets and
  reset values.
  Assumes it is included by bare name from the logic files.
*/
`ifndef BCD_BITOP_REGS_VH
`define BCD_BITOP_REGS_VH

// ==========================================================================
// Opcode bytes and ModRM subfield values
`define OP_ESCAPE 8'h0F
`define OP_DEC_ADD 8'h37
`define OP_DEC_SUB 8'h3F
`define OP_DEC_DIV 8'hD5
`define OP_DEC_MUL 8'hD4
`define OP_BASE_TEN 8'h0A
`define OP_PRIV_ADJ 8'h63
`define OP_LIMIT_CHK 8'h62
`define OP2_REWIND0 8'h3A
`define OP2_REWIND1 8'h3B
`define OP2_SCAN_LOW 8'hBC
`define OP2_SCAN_HIGH 8'hBD
`define OP2_BIT_IMM 8'hBA
`define OP2_BIT_CPL 8'hBB
`define OP2_BIT_CLR 8'hB3
`define SUB_BIT_CPL 3'h7
`define SUB_BIT_CLR 3'h6
`define SUB_BIT_SET 3'h5
`define MOD_REGISTER 2'h3

// ==========================================================================
// Clock counts, register or cache hit
`define CLK_DEC_ADD 6'h03
`define CLK_DEC_SUB 6'h03
`define CLK_DEC_DIV 6'h07
`define CLK_DEC_MUL 6'h13
`define CLK_PRIV_ADJ 6'h09
`define CLK_REWIND 6'h02
`define CLK_LIMIT_OUT 6'h08
`define CLK_LIMIT_IN 6'h07
`define CLK_SCAN_REG 6'h04
`define CLK_SCAN_LOW_MEM 6'h09
`define CLK_SCAN_HIGH_MEM 6'h0B
`define CLK_BIT_REG 6'h02
`define CLK_BIT_MEM 6'h08
`define CLK_ILLEGAL 6'h01

// ==========================================================================
// Flag bit positions within the 12-bit flag word
`define FLAG_CARRY 0
`define FLAG_PARITY 2
`define FLAG_AUX 4
`define FLAG_ZERO 6
`define FLAG_SIGN 7
`define FLAG_OVERFLOW 11

// ==========================================================================
// Register offsets, fields and reset values
`define REG_CONTROL 8'h00
`define REG_FLAGS 8'h04
`define REG_STATUS 8'h08
`define REG_RESULT 8'h0C
`define REG_LAST_COUNT 8'h10
`define CTRL_PROTECTED 0
`define STAT_BUSY 0
`define STAT_LIMIT_FAULT 1
`define STAT_ILLEGAL 2
`define CONTROL_RST 1'h0
`define FLAGS_RST 12'h000
`define RESULT_RST 32'h0000_0000

`endif

// ---- logic/bit_scan_unit.v ----
/*
  Finds the lowest or highest set bit of a word and reports how many bit
  positions were examined before the scan stopped.
  Assumes a purely combinational use by the execution unit.
*/
`timescale 1ns/1ps
`default_nettype none

module bit_scan_unit #(
  parameter WIDTH = 32
) (
  input wire [WIDTH-1:0] value,
  input wire reverse,
  output reg found,
  output reg [4:0] index,
  output reg [5:0] examined
);

  integer i;

  // ========================================================================
  // Scan
  // Loop order makes the last hit win: descending for lowest, ascending for highest
  always @* begin
    found = |value;
    index = 5'h00;
    if (reverse) begin
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (value[i]) index = i[4:0];
      end
    end else begin
      for (i = WIDTH - 1; i >= 0; i = i - 1) begin
        if (value[i]) index = i[4:0];
      end
    end
    // A zero word is examined in full
    if (!found) examined = WIDTH[5:0];
    else if (reverse) examined = WIDTH[5:0] - {1'b0, index};
    else examined = {1'b0, index} + 6'h01;
  end

endmodule // bit_scan_unit

`default_nettype wire

// ---- dv/bcd_bitop_props.sv ----
/*
  Checker for the decimal-adjust and bit-operation execution unit.
  Assumes it is bound to the unit's top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module bcd_bitop_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] opcode0,
  input wire logic [7:0] opcode1,
  input wire logic [7:0] modrm,
  input wire logic [31:0] operand_a,
  input wire logic [31:0] bound_lower,
  input wire logic [31:0] bound_upper,
  input wire logic busy,
  input wire logic done,
  input wire logic [11:0] flags_out,
  input wire logic bound_fault,
  input wire logic blit_buffer0_pointer_rewind,
  input wire logic blit_buffer1_pointer_rewind
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Helpers: a start only counts while idle, bounds compare signed
  wire logic take = start && !busy;
  wire logic outside = $signed(operand_a) < $signed(bound_lower) || $signed(operand_a) > $signed(bound_upper);
  wire logic [10:0] upper_flags = flags_out[11:1];
  sequence s_fin; done && !busy; endsequence
  // ==========================================================================
  // Done exactly N cycles after issue, with busy held throughout except in the limit and multiply checks
  property p_dec_add; take && opcode0 == 8'h37 |=> busy[*3] ##1 s_fin; endproperty
  a_dec_add: assert property (p_dec_add) else $error("adjust after add timing wrong");
  property p_dec_sub; take && opcode0 == 8'h3F |=> busy[*3] ##1 s_fin; endproperty
  a_dec_sub: assert property (p_dec_sub) else $error("adjust after subtract timing wrong");
  property p_dec_div; take && opcode0 == 8'hD5 && opcode1 == 8'h0A |=> busy[*7] ##1 s_fin; endproperty
  a_dec_div: assert property (p_dec_div) else $error("adjust before divide timing wrong");
  // Nineteen busy cycles: only the first eight are unrolled, done is pinned exactly
  property p_dec_mul; take && opcode0 == 8'hD4 && opcode1 == 8'h0A |=> busy[*8] ##12 s_fin; endproperty
  a_dec_mul: assert property (p_dec_mul) else $error("adjust after multiply timing wrong");
  property p_rew0; take && opcode0 == 8'h0F && opcode1 == 8'h3A |=> busy[*2] ##1 s_fin ##0 blit_buffer0_pointer_rewind; endproperty
  a_rew0: assert property (p_rew0) else $error("rewind 0 wrong");
  property p_rew1; take && opcode0 == 8'h0F && opcode1 == 8'h3B |=> busy[*2] ##1 s_fin ##0 blit_buffer1_pointer_rewind; endproperty
  a_rew1: assert property (p_rew1) else $error("rewind 1 wrong");
  property p_bound_out; take && opcode0 == 8'h62 && outside |-> ##9 done && bound_fault; endproperty
  a_bound_out: assert property (p_bound_out) else $error("limit fault missing");
  property p_bound_in; take && opcode0 == 8'h62 && !outside |-> ##8 done && !bound_fault && flags_out == $past(flags_out, 8); endproperty
  a_bound_in: assert property (p_bound_in) else $error("in-range limit check wrong");
  property p_scan_reg; take && opcode0 == 8'h0F && (opcode1 == 8'hBC || opcode1 == 8'hBD) && modrm[7:6] == 2'h3 |=> busy[*4] ##1 s_fin; endproperty
  a_scan_reg: assert property (p_scan_reg) else $error("register scan timing wrong");
  // Immediate bit ops touch carry only, so all flags above it must survive
  // Reg field 100 is the plain test form, refused here in one cycle, so only 101..111 count
  property p_bit_imm; take && opcode0 == 8'h0F && opcode1 == 8'hBA && modrm[5] && modrm[4:3] != 2'h0 |=> busy[*2] ##1 s_fin ##0 upper_flags == $past(upper_flags, 3); endproperty
  a_bit_imm: assert property (p_bit_imm) else $error("immediate bit op wrong");
endmodule // bcd_bitop_props

bind bcd_adjust_and_bit_op_execution bcd_bitop_props u_props (.clock, .rst, .start, .opcode0, .opcode1, .modrm,
  .operand_a, .bound_lower, .bound_upper, .busy, .done, .flags_out, .bound_fault, .blit_buffer0_pointer_rewind,
  .blit_buffer1_pointer_rewind);

`default_nettype wire

// ---- dv/bcd_adjust_and_bit_op_execution_test.sv ----
/*
  Self-checking bench for the decimal-adjust and bit-operation unit.
  Assumes the register map and flag positions of the shared header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcd_bitop_regs.vh"

module bcd_adjust_and_bit_op_execution_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] opcode0 = 8'h00, opcode1 = 8'h00, modrm = 8'h00, imm8 = 8'h00, address = 8'h00;
  logic [31:0] operand_a = 32'h0, operand_b = 32'h0, bound_lower = 32'h0, bound_upper = 32'h0, wdata = 32'h0;
  wire [31:0] rdata, result;
  wire [11:0] flags_out;
  wire busy, done, result_write, bound_fault, rew0, rew1, illegal_opcode;
  int fail_count = 0, n_checks = 0, tick = 0;
  logic [11:0] fl0;
  logic [4:0] pulses;
  logic [31:0] v;

  bcd_adjust_and_bit_op_execution dut (.clock(clock), .rst(rst), .start(start), .opcode0(opcode0),
    .opcode1(opcode1), .modrm(modrm), .imm8(imm8), .operand_a(operand_a), .operand_b(operand_b),
    .bound_lower(bound_lower), .bound_upper(bound_upper), .address(address), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .busy(busy), .done(done), .result(result), .result_write(result_write),
    .flags_out(flags_out), .bound_fault(bound_fault), .blit_buffer0_pointer_rewind(rew0),
    .blit_buffer1_pointer_rewind(rew1), .illegal_opcode(illegal_opcode));

  always #10 clock = ~clock;

  // Whole run is well under a thousand cycles; a hang is cut short here
  always @(posedge clock) begin
    tick <= tick + 1;
    if (tick == 3000) begin
      fail_count++;
      final_report();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Wide enough for a result beside the flag word and the side pulses
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clock);
    address <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Issue one instruction, count cycles to done and latch the side pulses
  task automatic run(input logic [7:0] o0, o1, m, im, input logic [31:0] a, b, input int n);
    int k;
    @(posedge clock);
    fl0 = flags_out;
    start <= 1'b1;
    opcode0 <= o0;
    opcode1 <= o1;
    modrm <= m;
    imm8 <= im;
    operand_a <= a;
    operand_b <= b;
    @(posedge clock);
    start <= 1'b0;
    k = 1;
    #1;
    while (done !== 1'b1 && k < 100) begin
      @(posedge clock);
      #1 k++;
    end
    pulses = {result_write, bound_fault, rew0, rew1, illegal_opcode};
    chk("cycles", k, n + 1);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    reg_rd(`REG_CONTROL);
    chk("control", v, 32'h0);
    reg_rd(`REG_FLAGS);
    chk("flags", v, 32'h0);
    reg_rd(8'h14);
    chk("unmapped", v, 32'h0);
  endtask

  task automatic t_adjust();
    reg_wr(`REG_FLAGS, 32'h0);
    run(8'h37, 8'h00, 8'h00, 8'h00, 32'h0000_000B, 32'h0, 3);
    chk("aaa", {result, flags_out[`FLAG_AUX], flags_out[`FLAG_CARRY], pulses}, {32'h0101, 2'h3, 5'h10});
    run(8'h3F, 8'h00, 8'h00, 8'h00, 32'h0000_020F, 32'h0, 3);
    chk("aas", {result, flags_out[`FLAG_AUX], flags_out[`FLAG_CARRY]}, {32'h0109, 2'h3});
    run(8'hD5, 8'h0A, 8'h00, 8'h00, 32'h0000_0207, 32'h0, 7);
    chk("aad", {result, flags_out[`FLAG_SIGN], flags_out[`FLAG_ZERO], flags_out[`FLAG_PARITY]}, {32'h1B, 3'h1});
    run(8'hD4, 8'h0A, 8'h00, 8'h00, 32'h0000_003F, 32'h0, 19);
    chk("aam", {result, flags_out[`FLAG_SIGN], flags_out[`FLAG_ZERO], flags_out[`FLAG_PARITY]}, {32'h0603, 3'h1});
    run(8'hD5, 8'h0B, 8'h00, 8'h00, 32'h0000_0207, 32'h0, 1);
    chk("bad base", pulses, 5'h01);
  endtask

  task automatic t_priv();
    run(8'h63, 8'h00, 8'hC1, 8'h00, 32'h1, 32'h3, 1);
    chk("real mode", pulses, 5'h01);
    reg_wr(`REG_CONTROL, 32'h1);
    run(8'h63, 8'h00, 8'hC1, 8'h00, 32'h1, 32'h3, 9);
    chk("raise", {result, flags_out, pulses}, {32'h3, fl0 | 12'h040, 5'h10});
    run(8'h63, 8'h00, 8'hC1, 8'h00, 32'h3, 32'h1, 9);
    chk("keep", {flags_out, pulses}, {fl0 & 12'hFBF, 5'h00});
    reg_wr(`REG_CONTROL, 32'h0);
  endtask

  task automatic t_rewind_bound();
    run(8'h0F, 8'h3A, 8'h00, 8'h00, 32'h0, 32'h0, 2);
    chk("rewind0", {flags_out, pulses}, {fl0, 5'h04});
    run(8'h0F, 8'h3B, 8'h00, 8'h00, 32'h0, 32'h0, 2);
    chk("rewind1", {flags_out, pulses}, {fl0, 5'h02});
    @(posedge clock);
    bound_lower <= 32'hFFFF_FFFE;
    bound_upper <= 32'h4;
    run(8'h62, 8'h00, 8'h00, 8'h00, 32'h5, 32'h0, 8);
    chk("out of range", {flags_out, pulses}, {fl0, 5'h08});
    // Minus one is inside only under a signed compare
    run(8'h62, 8'h00, 8'h00, 8'h00, 32'hFFFF_FFFF, 32'h0, 7);
    chk("in range", {flags_out, pulses}, {fl0, 5'h00});
  endtask

  // Sticky faults stand until written with ones; last count keeps the final N
  task automatic t_status();
    reg_rd(`REG_STATUS);
    chk("status", v, 32'h6);
    reg_rd(`REG_LAST_COUNT);
    chk("last count", v, 32'h7);
    reg_rd(`REG_RESULT);
    chk("result reg", v, 32'h3);
    reg_wr(`REG_STATUS, 32'h6);
    reg_rd(`REG_STATUS);
    chk("status clear", v, 32'h0);
  endtask

  task automatic scan(input logic [7:0] o1, m, input logic [31:0] b, input int n, input logic zf);
    run(8'h0F, o1, m, 8'h00, 32'h0, b, n);
    chk("scan", {flags_out, pulses[4]}, {fl0 & 12'hFBF | {5'h0, zf, 6'h0}, !zf});
    if (!zf) chk("scan index", result, 32'h8);
  endtask

  task automatic bitop(input logic [7:0] o1, m, im, input logic [31:0] a, b, input int n, input logic [31:0] r,
    input logic cf);
    run(8'h0F, o1, m, im, a, b, n);
    chk("bit op", {result, flags_out}, {r, fl0[11:1], cf});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_adjust();
    t_priv();
    t_rewind_bound();
    t_status();
    scan(8'hBC, 8'hC0, 32'h100, 4, 1'b0);
    scan(8'hBC, 8'h00, 32'h100, 18, 1'b0);
    scan(8'hBD, 8'h00, 32'h100, 35, 1'b0);
    scan(8'hBD, 8'hC0, 32'h0, 4, 1'b1);
    bitop(8'hBA, 8'hF8, 8'h03, 32'h8, 32'h0, 2, 32'h0, 1'b1);
    bitop(8'hBB, 8'hC0, 8'h00, 32'h0, 32'h4, 2, 32'h10, 1'b0);
    bitop(8'hBB, 8'h00, 8'h00, 32'h20, 32'h5, 8, 32'h0, 1'b1);
    bitop(8'hBA, 8'hF0, 8'h00, 32'h1, 32'h0, 2, 32'h0, 1'b1);
    bitop(8'hB3, 8'h00, 8'h00, 32'hFF, 32'h1, 8, 32'hFD, 1'b1);
    bitop(8'hBA, 8'hE8, 8'h1F, 32'h0, 32'h0, 2, 32'h8000_0000, 1'b0);
    final_report();
  end
endmodule // bcd_adjust_and_bit_op_execution_test

`default_nettype wire
